// ==== include/tcr_defs.svh ====
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TCR_IDX_ALIGN     10'h00f
`define TCR_IDX_PINCTL    10'h011
`define TCR_IDX_CARRIER   10'h012
`define TCR_IDX_MODDRV    10'h013

// ****************************************************************
// Field positions
// ****************************************************************
`define TCR_RXOFF_LSB     4
`define TCR_TXBITS_LSB    0
`define TCR_MODSRC_LSB    5
`define TCR_FORCE_BIT     4
`define TCR_INV_BIT       3
`define TCR_CW_BIT        2
`define TCR_RF2_BIT       1
`define TCR_RF1_BIT       0
`define TCR_COND_LSB      0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define TCR_RST_ALIGN     8'h00
`define TCR_RST_PINCTL    8'h58
`define TCR_RST_CARRIER   8'h3f
`define TCR_RST_MODDRV    8'h3f
`define TCR_BYTE_BITS     4'h8

`endif

// ==== include/tcr_pkg.sv ====
// ****************************************************************
// Shared types
// ****************************************************************
package tcr_pkg;

    // Modulator input sources
    typedef enum logic [1:0] {
        TCR_MOD_LOW  = 2'h0,
        TCR_MOD_HIGH = 2'h1,
        TCR_MOD_ENC  = 2'h2,
        TCR_MOD_EXT  = 2'h3
    } tcr_mod_src_t;

    // Transmit serialiser states, one-hot
    typedef enum logic [1:0] {
        TCR_TX_IDLE  = 2'b01,
        TCR_TX_SHIFT = 2'b10
    } tcr_tx_state_t;

endpackage : tcr_pkg

// ==== include/tcr_ctl_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Link between register bank and the data path modules
// ****************************************************************
interface tcr_ctl_if;
    logic [2:0] rx_offset;
    logic       rx_complete;
    logic [2:0] tx_last_bits;
    logic       tx_complete;
    logic       encoder_bit;
    logic       tx_active;

    modport regs (
        output rx_offset,
        output tx_last_bits,
        input  rx_complete,
        input  tx_complete,
        input  encoder_bit,
        input  tx_active
    );
    modport rx (
        input  rx_offset,
        output rx_complete
    );
    modport tx (
        input  tx_last_bits,
        output tx_complete,
        output encoder_bit,
        output tx_active
    );
endinterface : tcr_ctl_if

`default_nettype wire

// ==== logic/tcr_rx_pack.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Receive bit packer
// ****************************************************************
module tcr_rx_pack
    import tcr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pce,
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit,
    input  wire logic       rx_end,
    output logic            fifo_wr,
    output logic [7:0]      fifo_data,
    tcr_ctl_if.rx           ctl
);
    logic       active_q;
    logic [2:0] pos_q;
    logic [7:0] acc_q;
    logic       pend_q;
    logic [2:0] pos_now;
    logic [7:0] acc_now;

    // First bit of a frame starts at the programmed offset
    always_comb
    begin
        pos_now = active_q ? pos_q : ctl.rx_offset;
        acc_now = acc_q;
        acc_now[pos_now] = rx_bit;
    end

    // Bit placement, byte emission and end-of-frame flush
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_q        <= 1'b0;
            pos_q           <= 3'h0;
            acc_q           <= 8'h00;
            pend_q          <= 1'b0;
            fifo_wr         <= 1'b0;
            fifo_data       <= 8'h00;
            ctl.rx_complete <= 1'b0;
        end
        else if (pce)
        begin
            fifo_wr         <= 1'b0;
            ctl.rx_complete <= rx_end;
            if (rx_bit_valid && pos_now == 3'h7)
            begin
                // Wrap to bit 0 of the next byte
                fifo_wr   <= 1'b1;
                fifo_data <= acc_now;
                acc_q     <= 8'h00;
                pos_q     <= 3'h0;
                pend_q    <= 1'b0;
                active_q  <= !rx_end;
            end
            else if (rx_bit_valid)
            begin
                acc_q    <= acc_now;
                pos_q    <= pos_now + 3'h1;
                pend_q   <= 1'b1;
                active_q <= !rx_end;
                if (rx_end)
                begin
                    fifo_wr   <= 1'b1;
                    fifo_data <= acc_now;
                    acc_q     <= 8'h00;
                    pend_q    <= 1'b0;
                end
            end
            else if (rx_end)
            begin
                // Partial last byte still goes out
                fifo_wr   <= pend_q;
                fifo_data <= acc_q;
                acc_q     <= 8'h00;
                pend_q    <= 1'b0;
                active_q  <= 1'b0;
            end
        end
    end
endmodule : tcr_rx_pack

`default_nettype wire

// ==== logic/tcr_tx_ser.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"

// ****************************************************************
// Transmit byte serialiser, LSB first
// ****************************************************************
module tcr_tx_ser
    import tcr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pce,
    input  wire logic       tx_byte_valid,
    input  wire logic [7:0] tx_byte_data,
    input  wire logic       tx_byte_last,
    output logic            tx_byte_ready,
    tcr_ctl_if.tx           ctl
);
    tcr_tx_state_t state_q;
    logic [7:0]    shift_q;
    logic [3:0]    left_q;
    logic          last_q;
    logic [3:0]    count_d;

    // Final byte may be cut short; zero means all eight bits
    assign count_d = (tx_byte_last && ctl.tx_last_bits != 3'h0)
                   ? {1'b0, ctl.tx_last_bits}
                   : `TCR_BYTE_BITS;
    assign tx_byte_ready = pce && state_q == TCR_TX_IDLE;
    assign ctl.tx_active = state_q == TCR_TX_SHIFT;

    // Load, shift and finish
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q         <= TCR_TX_IDLE;
            shift_q         <= 8'h00;
            left_q          <= 4'h0;
            last_q          <= 1'b0;
            ctl.encoder_bit <= 1'b0;
            ctl.tx_complete <= 1'b0;
        end
        else if (pce)
        begin
            ctl.tx_complete <= 1'b0;
            unique case (state_q)
                TCR_TX_IDLE:
                begin
                    ctl.encoder_bit <= 1'b0;
                    if (tx_byte_valid)
                    begin
                        shift_q <= tx_byte_data;
                        left_q  <= count_d;
                        last_q  <= tx_byte_last;
                        state_q <= TCR_TX_SHIFT;
                    end
                end
                TCR_TX_SHIFT:
                begin
                    ctl.encoder_bit <= shift_q[0];
                    shift_q         <= {1'b0, shift_q[7:1]};
                    left_q          <= left_q - 4'h1;
                    if (left_q == 4'h1)
                    begin
                        state_q         <= TCR_TX_IDLE;
                        ctl.tx_complete <= last_q;
                    end
                end
            endcase
        end
    end
endmodule : tcr_tx_ser

`default_nettype wire

// ==== logic/tcr_tx_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"

// What this block does
// - The first received bit lands at the receive offset position, later bits climb.
// - With offset seven the second bit goes to bit 0 of the next byte.
// - The receive offset clears to zero when a reception completes.
// - Only final_byte_bit_count bits of the last byte are sent, zero means all.
// - The final byte bit count clears when a transmission finishes.
// - The modulator input is low, high, encoder or external pin per select.
// - Force full-depth keying makes modulation fully keyed.
// - The modulated conductance is ignored while full-depth keying is forced.
// - The second antenna carrier is inverted when the invert bit is 0.
// - The unmodulated bit gives a steady carrier on the second antenna pin.
// - The second antenna enable picks modulated carrier or constant level.
// - The first antenna enable picks modulated carrier or constant level.
// - The unmodulated conductance sets the driver strength outside modulation.
// - The modulated conductance sets the driver strength during modulation.
module tcr_tx_ctrl
    import tcr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_end,
    output logic             fifo_wr,
    output logic [7:0]       fifo_data,
    input  wire logic        tx_byte_valid,
    input  wire logic [7:0]  tx_byte_data,
    input  wire logic        tx_byte_last,
    output logic             tx_byte_ready,
    input  wire logic        external_modulation_input,
    input  wire logic        carrier_in,
    output logic             modulator_in,
    output logic             first_antenna_pin,
    output logic             second_antenna_pin,
    output logic [5:0]       drive_conductance,
    output logic             tx_busy
);

    // ************************************************************
    // Declarations
    // ************************************************************
    tcr_ctl_if ctl ();

    logic [2:0]   rx_offset_q;
    logic [2:0]   tx_last_bits_q;
    logic [7:0]   pin_ctl_q;
    logic [7:0]   carrier_q;
    logic [7:0]   moddrv_q;
    logic [31:0]  prdata_q;
    logic         pslverr_q;
    logic         mod_q;
    logic         pin1_q;
    logic         pin2_q;
    logic [5:0]   cond_q;

    logic         setup;
    logic         access;
    logic         wr_en;
    logic [9:0]   word_idx;
    logic         hit_align;
    logic         hit_pinctl;
    logic         hit_carrier;
    logic         hit_moddrv;
    logic         hit_any;
    logic [7:0]   rd_byte;
    tcr_mod_src_t mod_src;
    logic         mod_d;
    logic         force_full;
    logic         gap;
    logic         tx2_base;
    logic         pin1_d;
    logic         pin2_d;
    logic [5:0]   cond_d;

    // ************************************************************
    // APB decode
    // ************************************************************

    // Zero wait states; a frozen clock enable holds the access off
    assign setup    = psel && !penable;
    assign access   = psel && penable && pce;
    assign pready   = access;
    assign pslverr  = access && pslverr_q;
    assign prdata   = prdata_q;
    assign wr_en    = access && pwrite && pstrb[0] && !pslverr_q;
    assign word_idx = paddr[11:2];

    // One aligned word per register
    assign hit_align   = word_idx == `TCR_IDX_ALIGN;
    assign hit_pinctl  = word_idx == `TCR_IDX_PINCTL;
    assign hit_carrier = word_idx == `TCR_IDX_CARRIER;
    assign hit_moddrv  = word_idx == `TCR_IDX_MODDRV;
    assign hit_any     = hit_align || hit_pinctl
                      || hit_carrier || hit_moddrv;

    // Read mux; reserved alignment bits read as zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit_align)
        begin
            rd_byte[`TCR_RXOFF_LSB +: 3]  = rx_offset_q;
            rd_byte[`TCR_TXBITS_LSB +: 3] = tx_last_bits_q;
        end
        else if (hit_pinctl)
        begin
            rd_byte = pin_ctl_q;
        end
        else if (hit_carrier)
        begin
            rd_byte = carrier_q;
        end
        else if (hit_moddrv)
        begin
            rd_byte = moddrv_q;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else if (pce && setup)
        begin
            prdata_q  <= {24'h00_0000, rd_byte};
            pslverr_q <= !hit_any;
        end
    end

    // ************************************************************
    // Self-clearing alignment fields
    // ************************************************************

    // Receive offset; a write in the same cycle as the clear wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_offset_q <= 3'(`TCR_RST_ALIGN >> `TCR_RXOFF_LSB);
        end
        else if (pce)
        begin
            if (wr_en && hit_align)
            begin
                rx_offset_q <= pwdata[`TCR_RXOFF_LSB +: 3];
            end
            else if (ctl.rx_complete)
            begin
                rx_offset_q <= 3'h0;
            end
        end
    end

    // Final byte bit count, cleared after the last byte goes out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_last_bits_q <= 3'(`TCR_RST_ALIGN >> `TCR_TXBITS_LSB);
        end
        else if (pce)
        begin
            if (wr_en && hit_align)
            begin
                tx_last_bits_q <= pwdata[`TCR_TXBITS_LSB +: 3];
            end
            else if (ctl.tx_complete)
            begin
                tx_last_bits_q <= 3'h0;
            end
        end
    end

    assign ctl.rx_offset    = rx_offset_q;
    assign ctl.tx_last_bits = tx_last_bits_q;

    // ************************************************************
    // Pin control and conductance registers
    // ************************************************************

    // Fixed-zero bits are stored as written; software keeps them 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_ctl_q <= `TCR_RST_PINCTL;
            carrier_q <= `TCR_RST_CARRIER;
            moddrv_q  <= `TCR_RST_MODDRV;
        end
        else if (wr_en)
        begin
            if (hit_pinctl)
            begin
                pin_ctl_q <= pwdata[7:0];
            end
            if (hit_carrier)
            begin
                carrier_q <= pwdata[7:0];
            end
            if (hit_moddrv)
            begin
                moddrv_q <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Modulator and antenna drivers
    // ************************************************************

    assign mod_src    = tcr_mod_src_t'(pin_ctl_q[`TCR_MODSRC_LSB +: 2]);
    assign force_full = pin_ctl_q[`TCR_FORCE_BIT];

    // Modulator input source select
    always_comb
    begin
        unique case (mod_src)
            TCR_MOD_LOW:  mod_d = 1'b0;
            TCR_MOD_HIGH: mod_d = 1'b1;
            TCR_MOD_ENC:  mod_d = ctl.encoder_bit;
            TCR_MOD_EXT:  mod_d = external_modulation_input;
        endcase
    end

    // Full-depth keying blanks the carrier during modulation
    assign gap      = mod_d && force_full;
    assign tx2_base = pin_ctl_q[`TCR_CW_BIT]
                    ? carrier_in
                    : (carrier_in && !gap);
    assign pin1_d   = pin_ctl_q[`TCR_RF1_BIT]
                    ? (carrier_in && !gap)
                    : 1'b0;

    // Second pin: enable, then polarity (invert when bit is 0)
    always_comb
    begin
        if (!pin_ctl_q[`TCR_RF2_BIT])
        begin
            pin2_d = 1'b0;
        end
        else if (!pin_ctl_q[`TCR_INV_BIT])
        begin
            pin2_d = !tx2_base;
        end
        else
        begin
            pin2_d = tx2_base;
        end
    end

    // Conductance: modulated value only while modulating, unforced
    always_comb
    begin
        if (!mod_d)
        begin
            cond_d = carrier_q[`TCR_COND_LSB +: 6];
        end
        else if (force_full)
        begin
            cond_d = 6'h00;
        end
        else
        begin
            cond_d = moddrv_q[`TCR_COND_LSB +: 6];
        end
    end

    // Registered pin and strength outputs, one cycle behind the mux
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mod_q  <= 1'b0;
            pin1_q <= 1'b0;
            pin2_q <= 1'b0;
            cond_q <= 6'(`TCR_RST_CARRIER >> `TCR_COND_LSB);
        end
        else if (pce)
        begin
            mod_q  <= mod_d;
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
            cond_q <= cond_d;
        end
    end

    assign modulator_in       = mod_q;
    assign first_antenna_pin  = pin1_q;
    assign second_antenna_pin = pin2_q;
    assign drive_conductance  = cond_q;
    assign tx_busy            = ctl.tx_active;

    // ************************************************************
    // Data path modules
    // ************************************************************

    // Receive packer writes assembled bytes towards the FIFO
    tcr_rx_pack u_rx (
        .pclk         (pclk),
        .presetn      (presetn),
        .pce          (pce),
        .rx_bit_valid (rx_bit_valid),
        .rx_bit       (rx_bit),
        .rx_end       (rx_end),
        .fifo_wr      (fifo_wr),
        .fifo_data    (fifo_data),
        .ctl          (ctl.rx)
    );

    // Serialiser feeds the encoder bit to the modulator select
    tcr_tx_ser u_tx (
        .pclk          (pclk),
        .presetn       (presetn),
        .pce           (pce),
        .tx_byte_valid (tx_byte_valid),
        .tx_byte_data  (tx_byte_data),
        .tx_byte_last  (tx_byte_last),
        .tx_byte_ready (tx_byte_ready),
        .ctl           (ctl.tx)
    );

endmodule : tcr_tx_ctrl

`default_nettype wire

// ==== sim/tcr_tx_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// ************
// Port checker
// ************
module tcr_tx_ctrl_props
    import tcr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_bit_valid,
    input wire logic        rx_end,
    input wire logic        fifo_wr,
    input wire logic        tx_byte_valid,
    input wire logic        tx_byte_ready,
    input wire logic        tx_busy,
    input wire logic        carrier_in,
    input wire logic        first_antenna_pin,
    input wire logic        second_antenna_pin
);
    logic [3:0] busy_cnt_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Busy length; frozen with the enable so a stall is not a long byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_cnt_q <= 4'h0;
        else if (!tx_busy)
            busy_cnt_q <= 4'h0;
        else if (pce)
            busy_cnt_q <= busy_cnt_q + 4'h1;
    end

    pready_gen_a: assert property (pready == (psel && penable && pce))
        else $error("pready outside access phase");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without ready or with data");
    rdata_hi_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    fifo_cause_a: assert property (
        $rose(fifo_wr) |-> $past(pce && (rx_bit_valid || rx_end)))
        else $error("fifo write without a received bit or end");
    busy_start_a: assert property (
        $rose(tx_busy) |-> $past(tx_byte_valid && tx_byte_ready))
        else $error("busy without a byte taken");
    busy_len_a: assert property (busy_cnt_q <= 4'h8)
        else $error("more than eight bits shifted");
    ready_busy_a: assert property (tx_busy |-> !tx_byte_ready)
        else $error("byte accepted while shifting");
    pin_carrier_a: assert property (
        $rose(first_antenna_pin) |-> $past(carrier_in))
        else $error("first pin high without carrier");

    cover property ($rose(fifo_wr));
    cover property ($fell(tx_busy));
    cover property (pslverr);
    cover property ($rose(second_antenna_pin));
endmodule : tcr_tx_ctrl_props

bind tcr_tx_ctrl tcr_tx_ctrl_props u_props (.*);

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcr_defs.svh"

// ************
// Register bank bench
// ************
module tb
    import tcr_pkg::*;
;
    logic        pclk, presetn, pce, psel, penable, pwrite, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic        pready, pslverr, rx_bit_valid, rx_bit, rx_end, fifo_wr;
    logic [7:0]  fifo_data, tx_byte_data;
    logic        tx_byte_valid, tx_byte_last, tx_byte_ready, tx_busy;
    logic        external_modulation_input, carrier_in, modulator_in;
    logic        first_antenna_pin, second_antenna_pin;
    logic [5:0]  drive_conductance;
    int          err_total, n_compared, busy_n;
    logic [7:0]  fq[$];

    localparam logic [11:0] A_AL = {`TCR_IDX_ALIGN, 2'b00};
    localparam logic [11:0] A_PC = {`TCR_IDX_PINCTL, 2'b00};
    localparam logic [11:0] A_CW = {`TCR_IDX_CARRIER, 2'b00};
    localparam logic [11:0] A_MD = {`TCR_IDX_MODDRV, 2'b00};
    // Pin control values; bit 7 stays zero throughout
    localparam logic [7:0] PC [7] = '{8'h00, 8'h03, 8'h0b, 8'h3b,
                                      8'h3f, 8'h2f, 8'h7b};
    // Expected {modulator, pin1, pin2, conductance}
    localparam logic [8:0] PE [7] = '{9'h015, 9'h095, 9'h0d5, 9'h100,
                                      9'h140, 9'h1ea, 9'h100};
    localparam logic [2:0] OFS [3] = '{3'h0, 3'h3, 3'h7};
    localparam logic [2:0] LB [3] = '{3'h1, 3'h7, 3'h0};
    localparam logic [7:0] PAT = 8'hb6;

    always #50 pclk = ~pclk;

    tcr_tx_ctrl dut (.*);

    // Collect every byte handed to the FIFO
    always @(posedge pclk)
        if (fifo_wr === 1'b1)
            fq.push_back(fifo_data);

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk(input string w, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // One APB transfer; waits for pready, bounded
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            err_total++;
            give_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string w, input logic [11:0] a,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(w, e, rdat);
    endtask : rd

    // Hand one byte over, then count the shifting cycles
    task automatic send(input logic [7:0] d, input logic last);
        int i;
        @(posedge pclk);
        tx_byte_valid <= 1'b1;
        tx_byte_data  <= d;
        tx_byte_last  <= last;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (tx_byte_ready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            err_total++;
            give_verdict();
        end
        tx_byte_valid <= 1'b0;
        busy_n = 0;
        for (i = 0; i < 40; i++)
        begin
            @(posedge pclk);
            if (tx_busy === 1'b1)
                busy_n++;
            else if (busy_n > 0)
                break;
        end
    endtask : send

    // Hang guard
    initial
    begin
        repeat (30000) @(posedge pclk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, rx_bit_valid} = '0;
        {rx_bit, rx_end, tx_byte_valid, tx_byte_last} = '0;
        {paddr, pwdata, tx_byte_data} = '0;
        pce = 1'b1;
        pstrb = 4'hf;
        external_modulation_input = 1'b1;
        carrier_in = 1'b1;
        err_total = 0;
        n_compared = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;

        rd("align", A_AL, {24'h0, `TCR_RST_ALIGN});
        rd("pinctl", A_PC, {24'h0, `TCR_RST_PINCTL});
        rd("carrier", A_CW, {24'h0, `TCR_RST_CARRIER});
        rd("moddrv", A_MD, {24'h0, `TCR_RST_MODDRV});
        $display("test reset values done");

        apb(1'b1, A_CW, 32'h15);
        apb(1'b1, A_MD, 32'h2a);
        pstrb <= 4'h0;
        apb(1'b1, A_CW, 32'h33);
        pstrb <= 4'hf;
        rd("carrier", A_CW, 32'h15);
        rd("moddrv", A_MD, 32'h2a);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        $display("test register access done");

        // Receive eight bits at three offsets
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b1, A_AL, {25'h0, OFS[j], 4'h0});
            fq.delete();
            for (int k = 0; k < 8; k++)
            begin
                @(posedge pclk);
                rx_bit_valid <= 1'b1;
                rx_bit       <= PAT[k];
                rx_end       <= (k == 7);
            end
            @(posedge pclk);
            rx_bit_valid <= 1'b0;
            rx_end       <= 1'b0;
            repeat (4) @(posedge pclk);
            chk("fifo count", (OFS[j] == 0) ? 1 : 2, fq.size());
            chk("first byte", {24'h0, 8'(PAT << OFS[j])}, fq[0]);
            if (OFS[j] != 0)
                chk("next byte", PAT >> (8 - OFS[j]), fq[1]);
            rd("offset clear", A_AL, 32'h0);
        end
        $display("test receive alignment done");

        // Last-byte bit counts, including the all-bits code
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b1, A_AL, {29'h0, LB[j]});
            if (j == 0)
            begin
                send(8'h5a, 1'b0);
                chk("inner byte bits", 32'h8, busy_n);
            end
            send(8'ha5, 1'b1);
            chk("last byte bits", (LB[j] == 0) ? 8 : LB[j], busy_n);
            rd("count clear", A_AL, 32'h0);
        end
        $display("test transmit bit count done");

        // Modulator source, keying and pin modes
        for (int j = 0; j < 7; j++)
        begin
            apb(1'b1, A_PC, {24'h0, PC[j]});
            repeat (3) @(posedge pclk);
            chk("pins", {23'h0, PE[j]}, {23'h0, modulator_in,
                first_antenna_pin, second_antenna_pin,
                drive_conductance});
        end
        external_modulation_input <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("ext source", 32'h0d5, {23'h0, modulator_in,
            first_antenna_pin, second_antenna_pin, drive_conductance});
        // Without carrier both enabled pins must sit low
        carrier_in <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("no carrier", 32'h0, {30'h0, first_antenna_pin,
            second_antenna_pin});
        carrier_in <= 1'b1;
        rd("pinctl", A_PC, 32'h7b);
        $display("test pin modes done");
        give_verdict();
    end
endmodule : tb

`default_nettype wire
